// ==== hw/sfm_fault_monitor.sv ====
// encoder side fault detection and indication toward the evaluation unit
//
// Overview of operation
// - detected dangerous fault drives dedicated indication output
// - fault reaction completes within max reaction time
// - phasor check on raw samples, before regulation
// - incremental and absolute channels processed separately
// - duplicated diagnostics cross-compared for coverage
// - too few samples per period flags fault
// - every out-of-tolerance fault reaches indication
`timescale 1ns/10ps
module sfm_fault_monitor (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sample_vld_i,
  input wire logic signed [sfm_pkg::SIG_W-1:0] sin_raw_i,
  input wire logic signed [sfm_pkg::SIG_W-1:0] cos_raw_i,
  input wire logic period_mark_i,
  input wire logic [sfm_pkg::POS_W-1:0] inc_pos_i,
  input wire logic [sfm_pkg::POS_W-1:0] abs_pos_i,
  input wire logic [sfm_pkg::POS_W-1:0] pos_tol_i,
  output logic fault_ind_b_o,
  output logic fault_latched_o,
  output logic diag_mismatch_o,
  output logic [sfm_pkg::POS_W-1:0] encoder_abs_position_o
);
  // ----------------------------------------
  // duplicated phasor checkers
  // ----------------------------------------
  logic phs_bad_a; // channel a verdict
  logic phs_bad_b; // channel b verdict, same raw inputs
  // both instances see raw samples; any regulation sits after this point
  sfm_phasor_chk u_chk_a (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .sample_vld_i(sample_vld_i),
    .sin_i(sin_raw_i),
    .cos_i(cos_raw_i),
    .phs_bad_o(phs_bad_a)
  );
  sfm_phasor_chk u_chk_b (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .sample_vld_i(sample_vld_i),
    .sin_i(sin_raw_i),
    .cos_i(cos_raw_i),
    .phs_bad_o(phs_bad_b)
  );
  // ----------------------------------------
  // checker self-diagnosis
  // ----------------------------------------
  logic chk_diff_ff; // the two checkers disagree
  // a disagreement means one checker is broken, so it counts as a fault
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chk_diff_ff <= 1'b0;
    end else begin
      chk_diff_ff <= phs_bad_a ^ phs_bad_b;
    end
  end
  // ----------------------------------------
  // sample density per signal period
  // ----------------------------------------
  logic [7:0] smp_cnt_ff; // samples since last period mark
  logic smp_low_ff; // period ended with too few samples
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      smp_cnt_ff <= sfm_pkg::SMP_CNT_RST;
    end else if (period_mark_i) begin
      smp_cnt_ff <= sfm_pkg::SMP_CNT_RST;
    end else if (sample_vld_i && smp_cnt_ff != 8'hFF) begin
      smp_cnt_ff <= smp_cnt_ff + 8'h01; // saturating
    end
  end
  // interpolation unreliable when the period is undersampled
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      smp_low_ff <= 1'b0;
    end else begin
      smp_low_ff <= period_mark_i && (smp_cnt_ff < sfm_pkg::MIN_SAMPLES);
    end
  end
  // ----------------------------------------
  // channel separation check
  // ----------------------------------------
  // incremental and absolute paths arrive through separate ports; only the
  // absolute value is forwarded, so a shared fault cannot move both unseen
  function automatic logic [sfm_pkg::POS_W-1:0] abs_diff(input logic [sfm_pkg::POS_W-1:0] a,
                                                          input logic [sfm_pkg::POS_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction
  logic chan_bad_ff; // internal channels drifted apart
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_bad_ff <= 1'b0;
    end else begin
      chan_bad_ff <= abs_diff(inc_pos_i, abs_pos_i) > pos_tol_i;
    end
  end
  // forwarded absolute value, never derived from the incremental path
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      encoder_abs_position_o <= sfm_pkg::POS_RST;
    end else begin
      encoder_abs_position_o <= abs_pos_i;
    end
  end
  // ----------------------------------------
  // fault collection and reaction
  // ----------------------------------------
  logic any_fault; // any diagnostic fires
  always_comb begin
    any_fault = phs_bad_a | phs_bad_b | chk_diff_ff | smp_low_ff | chan_bad_ff;
  end
  sfm_pkg::sfm_state_type state_ff;
  sfm_pkg::sfm_state_type nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sfm_pkg::SFM_OK: begin
        if (any_fault) begin
          nxt_state = sfm_pkg::SFM_REACT;
        end
      end
      sfm_pkg::SFM_REACT: begin
        nxt_state = sfm_pkg::SFM_LATCH;
      end
      default: begin
        nxt_state = sfm_pkg::SFM_LATCH; // held until reset
      end
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= sfm_pkg::SFM_OK;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // indication is fail-safe: low means fault, so a dead line reads as fault
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_ind_b_o <= 1'b1;
    end else begin
      fault_ind_b_o <= !(any_fault || state_ff != sfm_pkg::SFM_OK);
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_latched_o <= 1'b0;
    end else if (state_ff == sfm_pkg::SFM_REACT) begin
      fault_latched_o <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      diag_mismatch_o <= 1'b0;
    end else if (chk_diff_ff) begin
      diag_mismatch_o <= 1'b1; // sticky
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int REACT_MAX = sfm_pkg::REACT_CYCLES; // reaction bound in cycles, local for the delay range
  chk_react_bound: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    any_fault |-> ##[1:REACT_MAX] !fault_ind_b_o)
    else $error("fault not indicated in time");
  chk_ind_hold: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (state_ff != sfm_pkg::SFM_OK) |=> !fault_ind_b_o)
    else $error("indication released after fault");
  chk_ind_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (!any_fault && state_ff == sfm_pkg::SFM_OK) |=> fault_ind_b_o)
    else $error("indication without cause");
  chk_phasor_raw: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (sample_vld_i && sin_raw_i == '0 && cos_raw_i == '0) |=> ##1 !fault_ind_b_o)
    else $error("zero phasor not flagged");
  chk_dup_diff: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (phs_bad_a != phs_bad_b) |=> ##1 diag_mismatch_o)
    else $error("checker disagreement missed");
  chk_undersample: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (period_mark_i && smp_cnt_ff < sfm_pkg::MIN_SAMPLES) |=> ##1 !fault_ind_b_o)
    else $error("undersampled period missed");
  chk_chan_apart: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (abs_diff(inc_pos_i, abs_pos_i) > pos_tol_i) |=> ##1 !fault_ind_b_o)
    else $error("channel drift missed");
  chk_abs_fwd: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    1'b1 |=> encoder_abs_position_o == $past(abs_pos_i))
    else $error("absolute value not forwarded");
  chk_latch_set: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(state_ff == sfm_pkg::SFM_REACT) |=> fault_latched_o [*3])
    else $error("fault latch not held");
endmodule

// ==== hw/sfm_phasor_chk.sv ====
// one independent phasor length checker channel
`timescale 1ns/10ps
module sfm_phasor_chk (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sample_vld_i,
  input wire logic signed [sfm_pkg::SIG_W-1:0] sin_i,
  input wire logic signed [sfm_pkg::SIG_W-1:0] cos_i,
  output logic phs_bad_o
);
  // ----------------------------------------
  // squared length, raw unregulated samples
  // ----------------------------------------
  logic signed [2*sfm_pkg::SIG_W-1:0] sin_sq; // full-width square, never truncated
  logic signed [2*sfm_pkg::SIG_W-1:0] cos_sq; // full-width square, never truncated
  logic [sfm_pkg::PHS_W-1:0] nxt_len; // sin^2 + cos^2
  // operands widen to the product width before the multiply, so no bits are lost
  always_comb begin
    sin_sq = sin_i * sin_i;
    cos_sq = cos_i * cos_i;
    nxt_len = {1'b0, sin_sq} + {1'b0, cos_sq}; // squares are never negative
  end
  // registered compare, one cycle latency
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phs_bad_o <= 1'b0;
    end else if (sample_vld_i) begin
      phs_bad_o <= (nxt_len < sfm_pkg::PHS_MIN) || (nxt_len > sfm_pkg::PHS_MAX);
    end
  end
endmodule

// ==== include/sfm_pkg.sv ====
// constants and types for the encoder fault monitor
package sfm_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100; // 10 MHz core clock
  localparam int REACT_TIME_NS = 1000; // max fault reaction time
  localparam int REACT_CYCLES = (REACT_TIME_NS / CLK_PERIOD_NS); // round down, longest time
  localparam int DIAG_TIME_NS = 500; // diagnostic evaluation window
  localparam int DIAG_CYCLES = (DIAG_TIME_NS / CLK_PERIOD_NS);
  localparam logic [3:0] DIAG_CYCLES_W = 4'(DIAG_CYCLES); // diag timeout count
  // ----------------------------------------
  // widths, thresholds and reset values
  // ----------------------------------------
  localparam int SIG_W = 12; // signed sine/cosine sample width
  localparam int POS_W = 16; // absolute position width
  localparam int PHS_W = 2 * SIG_W + 1; // phasor length squared width
  localparam logic [PHS_W-1:0] PHS_MIN = 25'h0040000; // minimum phasor length squared
  localparam logic [PHS_W-1:0] PHS_MAX = 25'h0400000; // maximum phasor length squared
  localparam logic [7:0] MIN_SAMPLES = 8'h08; // least samples per signal period
  localparam logic [7:0] SMP_CNT_RST = 8'h00; // sample counter after reset
  localparam logic [POS_W-1:0] POS_RST = 16'h0000; // position after reset
  // ----------------------------------------
  // fault indication state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    SFM_OK = 2'b00, // no fault seen
    SFM_REACT = 2'b01, // fault seen, indication driven
    SFM_LATCH = 2'b10 // fault held until reset
  } sfm_state_type;
endpackage

// ==== verification/safe_position_fault_monitor_tb_top.sv ====
// self-checking bench for the encoder fault monitor
`timescale 1ns/10ps
module safe_position_fault_monitor_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic vld = 1'b0, mark = 1'b0, step = 1'b0, ref_p = 1'b0;
  logic signed [sfm_pkg::SIG_W-1:0] sin_s = 12'h000, cos_s = 12'h000;
  logic [15:0] inc = 16'h0000, abs_p = 16'h0000, tol = 16'h0001, prev_abs = 16'h0000;
  logic ind_b, lat, mis, pos_flt;
  logic [15:0] enc_abs;
  logic [15:0] seed = 16'hBC01; // lfsr start, 48129
  int fails = 0, checks = 0, cyc = 0, fault_at = -1, cnt = 0, kind;
  always #50 core_clk_i = ~core_clk_i;
  sfm_fault_monitor uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sample_vld_i(vld), .sin_raw_i(sin_s),
    .cos_raw_i(cos_s), .period_mark_i(mark), .inc_pos_i(inc), .abs_pos_i(abs_p), .pos_tol_i(tol),
    .fault_ind_b_o(ind_b), .fault_latched_o(lat), .diag_mismatch_o(mis), .encoder_abs_position_o(enc_abs));
  sfm_eval_model eval (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ref_i(ref_p), .ref_pos_i(16'h0000),
    .step_i(step), .enc_abs_i(enc_abs), .tol_i(16'h0002), .fault_ind_b_i(ind_b), .pos_fault_o(pos_flt));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // reset, then reference the partner at release
  // ----------------------------------------
  task automatic do_reset();
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    vld <= 1'b0;
    mark <= 1'b0;
    step <= 1'b0;
    inc <= 16'h0000;
    abs_p <= 16'h0000;
    repeat (3) @(posedge core_clk_i);
    cmp("fault_ind_b_o", 16'h0001, 16'(ind_b));
    rst_b_i <= 1'b1;
    ref_p <= 1'b1;
    fault_at = -1;
    cnt = 0;
    prev_abs = 16'h0000;
    cyc = 0;
  endtask
  // ----------------------------------------
  // one cycle of stimulus plus model compare
  // ----------------------------------------
  task automatic drive(input logic v, input int s, input int c, input logic m, input int dlt);
    int ph;
    logic [15:0] inc_n;
    ph = s * s + c * c;
    inc_n = inc + 16'(m);
    @(posedge core_clk_i);
    vld <= v;
    sin_s <= 12'(s);
    cos_s <= 12'(c);
    mark <= m;
    step <= m;
    ref_p <= 1'b0;
    inc <= inc_n;
    abs_p <= inc_n + 16'(dlt);
    // any cause shows at the indication two edges later
    if (fault_at < 0 && ((v && (ph < int'(sfm_pkg::PHS_MIN) || ph > int'(sfm_pkg::PHS_MAX)))
        || (m && cnt < int'(sfm_pkg::MIN_SAMPLES)) || dlt > int'(tol)))
      fault_at = cyc + 2;
    if (m) cnt = 0;
    else if (v && cnt < 255) cnt++;
    @(negedge core_clk_i);
    cmp("fault_ind_b_o", (fault_at >= 0 && cyc >= fault_at) ? 16'h0000 : 16'h0001, 16'(ind_b));
    cmp("fault_latched_o", 16'(fault_at >= 0 && cyc > fault_at), 16'(lat));
    cmp("diag_mismatch_o", 16'h0000, 16'(mis));
    cmp("encoder_abs_position_o", prev_abs, enc_abs);
    prev_abs = inc_n + 16'(dlt);
    cyc++;
  endtask
  // kinds: 0 clean, 1 phasor too short, 2 phasor too long, 3 undersampled, 4 drift
  initial begin
    int s;
    for (kind = 0; kind < 5; kind++) begin
      do_reset();
      for (int p = 0; p < 4; p++) begin
        for (int i = 0; i < ((kind == 3 && p == 2) ? 7 : 8); i++) begin
          seed = lfsr(seed);
          s = 'h300 + int'(seed[7:0]);
          if ((kind == 1 || kind == 2) && p == 1 && i == 3)
            drive(1'b1, (kind == 1) ? 0 : 'h7FF, (kind == 1) ? 0 : 'h7FF, 1'b0, 0);
          else
            drive(1'b1, s, -s, 1'b0, (kind == 4 && p == 2) ? 5 : int'(seed[8]));
        end
        drive(1'b0, 0, 0, 1'b1, 0);
      end
      cmp("pos_fault_o", 16'(kind != 0), 16'(pos_flt));
    end
    wrap_up();
  end
  // watchdog, far beyond the roughly two hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge core_clk_i);
    fails++;
    wrap_up();
  end
endmodule

// ==== verification/sfm_eval_model.sv ====
// evaluation unit model: counts increments and cross-checks positions
`timescale 1ns/10ps
module sfm_eval_model (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ref_i,
  input wire logic [sfm_pkg::POS_W-1:0] ref_pos_i,
  input wire logic step_i,
  input wire logic [sfm_pkg::POS_W-1:0] enc_abs_i,
  input wire logic [sfm_pkg::POS_W-1:0] tol_i,
  input wire logic fault_ind_b_i,
  output logic pos_fault_o
);
  logic [sfm_pkg::POS_W-1:0] cnt_ff; // counted absolute position
  logic [sfm_pkg::POS_W-1:0] dif; // distance between both positions
  assign dif = (cnt_ff > enc_abs_i) ? cnt_ff - enc_abs_i : enc_abs_i - cnt_ff;
  // counter loads only from the machine reference, never from the encoder
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_ff <= 16'h0000;
    else if (ref_i) cnt_ff <= ref_pos_i;
    else if (step_i) cnt_ff <= cnt_ff + 16'h0001;
  end
  // sticky flag, cleared only by reset or a new referencing
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) pos_fault_o <= 1'b0;
    else if (ref_i) pos_fault_o <= 1'b0;
    else if (!fault_ind_b_i || dif > tol_i) pos_fault_o <= 1'b1;
  end
endmodule
